// *** core/dynamic_range_control.sv ***
`timescale 1ns/1ps
// Behaviour
// - compressor tap selectable before or after volume and loudness
// - compressor samples are top 32 bits of 48-bit word
// - 48-bit word is serial sample with eight bits above and below
// - full-scale sample reaches detector 48 dB down
// - thresholds held as 48-bit values, 23 fraction bits
// - offsets 48-bit log values, positive cuts, negative boosts
// - slopes are 28-bit signed values, 23 fraction bits
// - shared compressor forwards larger per-channel estimate each sample
// - one energy weight pair drives both shared estimators, channel 8 estimator its own
// - engine takes log level, picks region, computes gain
// - rising gain smoothed by decay, falling gain by attack
// - upper threshold splits high/mid, lower splits mid/low
// - zero upper offset gives unity gain at upper threshold
// - high slope above, mid between, low slope below from lower offset
// - curve continuous at upper threshold, jumps to lower offset
// - dedicated input mixers scale compressor input
// - first compressor serves 1-7 or 1-4,7; second serves channel 8
// - gain in 5.23 per estimate, multiplied with audio
module dynamic_range_control
  import dynamics_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       sample_valid,
  input  wire logic [CHANNELS*SERIAL_W-1:0] pre_volume_audio,
  input  wire logic [CHANNELS*SERIAL_W-1:0] post_volume_audio,
  input  wire logic                       multi_tap_post,
  input  wire logic                       single_tap_post,
  input  wire logic                       multi_enable,
  input  wire logic                       single_enable,
  input  wire logic                       six_channel_mode,
  input  wire logic [COEF_W-1:0]          input_mix_gain,
  input  wire curve_type                  multi_curve,
  input  wire curve_type                  single_curve,
  input  wire timing_type                 multi_timing,
  input  wire timing_type                 single_timing,
  output logic      [CHANNELS*SERIAL_W-1:0] audio_out,
  output logic                            audio_out_valid,
  output logic      [COEF_W-1:0]          multi_gain,
  output logic      [COEF_W-1:0]          single_gain
);

  // ****************************************
  // helpers
  // ****************************************
  // 48-bit internal word from a serial sample
  function automatic logic [WORD_W-1:0] widen(input logic [SERIAL_W-1:0] s);
    widen = {{HEADROOM_BITS{s[SERIAL_W-1]}}, s, {PRECISION_BITS{1'b0}}};
  endfunction

  // scaled compressor input from the top 32 bits
  function automatic logic [DRC_IN_W-1:0] tap(input logic [SERIAL_W-1:0] s,
                                              input logic [COEF_W-1:0]   g);
    logic [WORD_W-1:0]        w;
    logic signed [DRC_IN_W+COEF_W-1:0] p;
    w   = widen(s);
    p   = $signed(w[WORD_W-1 -: DRC_IN_W]) * $signed(g);
    tap = p[FRAC_BITS +: DRC_IN_W];
  endfunction

  // half log2 of level (log2 of rms) in 25.23, negative below full scale
  function automatic logic [WORD_W-1:0] log_level(input logic [WORD_W-1:0] v);
    logic [5:0]          msb;
    logic [WORD_W-1:0]   norm;
    logic [WORD_W-1:0]   res;
    msb  = 6'h00;
    for (int i = 0; i < WORD_W; i++) begin
      if (v[i]) begin
        msb = i[5:0];
      end
    end
    norm = v << (6'(WORD_W - 1) - msb);
    // half per doubling: level is energy, log of rms
    res  = {{(LOG_INT_W-6){1'b0}}, msb, norm[WORD_W-2 -: FRAC_BITS]};
    log_level = (res >>> 1) - 48'(((WORD_W - 1) << FRAC_BITS) >> 1);
  endfunction

  // slope times distance, 25.23 result
  function automatic logic [WORD_W-1:0] slope_mul(input logic [WORD_W-1:0] d,
                                                 input logic [COEF_W-1:0] k);
    logic signed [WORD_W+COEF_W-1:0] p;
    p = $signed(d) * $signed(k);
    slope_mul = p[FRAC_BITS +: WORD_W];
  endfunction

  // log-domain attenuation to linear 5.23 coefficient
  function automatic logic [COEF_W-1:0] to_gain(input logic [WORD_W-1:0] att);
    logic signed [WORD_W-1:0] a;
    logic [COEF_W-1:0]        g;
    logic [FRAC_BITS-1:0]     f;
    a = $signed(att);
    f = a[FRAC_BITS-1:0];
    // 2^-frac approximated linearly: 1 - frac/2
    g = UNITY_COEF - 28'({5'h00, f} >> 1);
    if (a < 0) begin
      // any boost gives a gain of eight so the sign bit stays clear
      g = UNITY_COEF << 3;
    end else if (a[WORD_W-1:FRAC_BITS] > 25'd26) begin
      g = 28'h0000000;
    end else begin
      g = g >> a[FRAC_BITS +: 5];
    end
    to_gain = g;
  endfunction

  // gain from level via three-region curve
  function automatic logic [COEF_W-1:0] curve_gain(input logic [WORD_W-1:0] lvl,
                                                  input curve_type c);
    logic signed [WORD_W-1:0] l;
    logic [WORD_W-1:0]        att;
    region_type               reg_sel;
    l = $signed(log_level(lvl));
    if (l >= $signed(c.high_threshold)) begin
      reg_sel = region_high;
    end else if (l >= $signed(c.low_threshold)) begin
      reg_sel = region_mid;
    end else begin
      reg_sel = region_low;
    end
    case (reg_sel)
      // anchored at upper offset, continuous there
      region_high: att = c.high_offset -
                         slope_mul(48'(l - c.high_threshold), c.high_slope);
      region_mid:  att = c.high_offset -
                         slope_mul(48'(l - c.high_threshold), c.mid_slope);
      // snapped to the lower offset
      region_low:  att = c.low_offset -
                         slope_mul(48'(l - c.low_threshold), c.low_slope);
      default:     att = c.high_offset;
    endcase
    curve_gain = to_gain(att);
  endfunction

  // smoothing with attack or decay
  function automatic logic [COEF_W-1:0] smooth(input logic [COEF_W-1:0] prev,
                                              input logic [COEF_W-1:0] tgt,
                                              input timing_type t);
    logic [COEF_W-1:0]     w;
    logic [COEF_W-1:0]     wc;
    logic [2*COEF_W:0]     s;
    w  = (tgt > prev) ? t.decay_weight : t.attack_weight;
    wc = (tgt > prev) ? t.decay_complement : t.attack_complement;
    s  = (2*COEF_W+1)'(tgt) * w + (2*COEF_W+1)'(prev) * wc;
    smooth = s[FRAC_BITS +: COEF_W];
  endfunction

  // apply gain to one sample
  function automatic logic [SERIAL_W-1:0] apply(input logic [SERIAL_W-1:0] s,
                                               input logic [COEF_W-1:0]   g);
    logic signed [SERIAL_W+COEF_W-1:0] p;
    p = $signed(s) * $signed(g);
    apply = p[FRAC_BITS +: SERIAL_W];
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CHANNELS*SERIAL_W-1:0] audio;
    logic                         valid;
    logic [COEF_W-1:0]            multi_gain;
    logic [COEF_W-1:0]            single_gain;
  } drc_state_type;

  drc_state_type state_q;
  drc_state_type state_d;

  logic [CHANNELS*SERIAL_W-1:0] src;
  logic [DRC_IN_W-1:0]          in_a;
  logic [DRC_IN_W-1:0]          in_b;
  logic [DRC_IN_W-1:0]          in_c;
  logic [WORD_W-1:0]            lvl_a;
  logic [WORD_W-1:0]            lvl_b;
  logic [WORD_W-1:0]            lvl_c;
  logic [WORD_W-1:0]            lvl_max;
  logic [SERIAL_W-1:0]          multi_src;
  logic [SERIAL_W-1:0]          single_src;

  // ****************************************
  // tap and estimators
  // ****************************************
  always_comb begin
    for (int ch = 0; ch < CHANNELS - 1; ch++) begin
      src[ch*SERIAL_W +: SERIAL_W] = multi_tap_post ?
          post_volume_audio[ch*SERIAL_W +: SERIAL_W] :
          pre_volume_audio[ch*SERIAL_W +: SERIAL_W];
    end
    src[(CHANNELS-1)*SERIAL_W +: SERIAL_W] = single_tap_post ?
        post_volume_audio[(CHANNELS-1)*SERIAL_W +: SERIAL_W] :
        pre_volume_audio[(CHANNELS-1)*SERIAL_W +: SERIAL_W];
    multi_src  = src[0 +: SERIAL_W];
    single_src = src[(CHANNELS-1)*SERIAL_W +: SERIAL_W];
  end

  assign in_a = tap(multi_src, input_mix_gain);
  assign in_b = tap(src[SERIAL_W +: SERIAL_W], input_mix_gain);
  assign in_c = tap(single_src, input_mix_gain);

  // one shared weight pair for both shared estimators
  level_estimator est_a (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .sample_valid      (sample_valid),
    .sample            (in_a),
    .energy_weight     (multi_timing.energy_weight),
    .energy_complement (multi_timing.energy_complement),
    .level             (lvl_a)
  );

  level_estimator est_b (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .sample_valid      (sample_valid),
    .sample            (in_b),
    .energy_weight     (multi_timing.energy_weight),
    .energy_complement (multi_timing.energy_complement),
    .level             (lvl_b)
  );

  level_estimator est_c (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .sample_valid      (sample_valid),
    .sample            (in_c),
    .energy_weight     (single_timing.energy_weight),
    .energy_complement (single_timing.energy_complement),
    .level             (lvl_c)
  );

  assign lvl_max = (lvl_a > lvl_b) ? lvl_a : lvl_b;

  // ****************************************
  // gain and mixing
  // ****************************************
  always_comb begin
    state_d       = state_q;
    state_d.valid = sample_valid;
    if (sample_valid) begin
      state_d.multi_gain = multi_enable ?
          smooth(state_q.multi_gain, curve_gain(lvl_max, multi_curve), multi_timing) :
          UNITY_COEF;
      state_d.single_gain = single_enable ?
          smooth(state_q.single_gain, curve_gain(lvl_c, single_curve), single_timing) :
          UNITY_COEF;
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (ch == CHANNELS - 1) begin
          state_d.audio[ch*SERIAL_W +: SERIAL_W] =
              apply(src[ch*SERIAL_W +: SERIAL_W], state_q.single_gain);
        end else if (six_channel_mode && (ch == 4 || ch == 5)) begin
          state_d.audio[ch*SERIAL_W +: SERIAL_W] = src[ch*SERIAL_W +: SERIAL_W];
        end else begin
          state_d.audio[ch*SERIAL_W +: SERIAL_W] =
              apply(src[ch*SERIAL_W +: SERIAL_W], state_q.multi_gain);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q.audio       <= '0;
      state_q.valid       <= 1'b0;
      state_q.multi_gain  <= UNITY_COEF;
      state_q.single_gain <= UNITY_COEF;
    end else begin
      state_q <= state_d;
    end
  end

  assign audio_out       = state_q.audio;
  assign audio_out_valid = state_q.valid;
  assign multi_gain      = state_q.multi_gain;
  assign single_gain     = state_q.single_gain;

endmodule

// *** core/dynamics_pkg.sv ***
package dynamics_pkg;

  // ****************************************
  // widths and formats
  // ****************************************
  localparam int SERIAL_W      = 32;
  localparam int WORD_W        = 48;
  localparam int HEADROOM_BITS = 8;
  localparam int PRECISION_BITS = 8;
  localparam int DRC_IN_W      = 32;
  localparam int COEF_W        = 28;
  localparam int FRAC_BITS     = 23;
  localparam int CHANNELS      = 8;

  // ****************************************
  // reset values and log integer width
  // ****************************************
  localparam logic [COEF_W-1:0] UNITY_COEF      = 28'h0800000;
  localparam logic [COEF_W-1:0] ENERGY_DEFAULT  = 28'h000883F;
  localparam logic [COEF_W-1:0] ATTACK_DEFAULT  = 28'h000883F;
  localparam logic [COEF_W-1:0] DECAY_DEFAULT   = 28'h00000AE;
  localparam logic [WORD_W-1:0] LEVEL_RESET     = 48'h000000000000;
  localparam int                LOG_INT_W       = 25;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [WORD_W-1:0] low_threshold;
    logic [WORD_W-1:0] high_threshold;
    logic [WORD_W-1:0] low_offset;
    logic [WORD_W-1:0] high_offset;
    logic [COEF_W-1:0] low_slope;
    logic [COEF_W-1:0] mid_slope;
    logic [COEF_W-1:0] high_slope;
  } curve_type;

  typedef struct packed {
    logic [COEF_W-1:0] energy_weight;
    logic [COEF_W-1:0] energy_complement;
    logic [COEF_W-1:0] attack_weight;
    logic [COEF_W-1:0] attack_complement;
    logic [COEF_W-1:0] decay_weight;
    logic [COEF_W-1:0] decay_complement;
  } timing_type;

  typedef enum {
    region_low,
    region_mid,
    region_high
  } region_type;

endpackage

// *** core/level_estimator.sv ***
`timescale 1ns/1ps
module level_estimator
  import dynamics_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                sample_valid,
  input  wire logic [DRC_IN_W-1:0] sample,
  input  wire logic [COEF_W-1:0]   energy_weight,
  input  wire logic [COEF_W-1:0]   energy_complement,
  output logic      [WORD_W-1:0]   level
);

  typedef struct packed {
    logic [WORD_W-1:0] level;
  } est_state_type;

  est_state_type state_q;
  est_state_type state_d;

  logic signed [2*DRC_IN_W-1:0] square;
  logic        [WORD_W-1:0]     energy;
  logic        [WORD_W+COEF_W-1:0] prod_new;
  logic        [WORD_W+COEF_W-1:0] prod_old;
  logic        [WORD_W+COEF_W-1:0] sum;

  // ****************************************
  // squared-level recursion, state registered
  // ****************************************
  always_comb begin
    state_d  = state_q;
    square   = $signed(sample) * $signed(sample);
    energy   = square[2*DRC_IN_W-2 -: WORD_W];
    prod_new = energy * energy_weight;
    prod_old = state_q.level * energy_complement;
    sum      = prod_new + prod_old;
    if (sample_valid) begin
      state_d.level = sum[FRAC_BITS +: WORD_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q.level <= LEVEL_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = state_q.level;

endmodule

// *** verification/audio_source.sv ***
`timescale 1ns/1ps
// ****************************************
// upstream sample stream, kinds: 0 quiet, 1 loud, 2 any, 3 copy of pre
// ****************************************
module audio_source
  import dynamics_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         run,
  input  wire logic [3:0]                   period,
  input  wire logic [1:0]                   kind_pre,
  input  wire logic [1:0]                   kind_post,
  output logic                              sample_valid,
  output logic      [CHANNELS*SERIAL_W-1:0] pre_audio,
  output logic      [CHANNELS*SERIAL_W-1:0] post_audio
);
  int                  seed = 39434;
  logic [3:0]          gap_q = 4'h0;
  logic [SERIAL_W-1:0] w_pre;
  logic [SERIAL_W-1:0] w_post;

  function logic [SERIAL_W-1:0] pick_word(input logic [1:0] kind);
    logic [31:0] r;
    r = $random(seed);
    case (kind)
      2'h0:    pick_word = {{24{r[7]}}, r[7:0]};
      2'h1:    pick_word = r[31] ? {8'h80, r[23:0]} : {8'h7F, r[23:0]};
      default: pick_word = r;
    endcase
  endfunction

  initial begin
    sample_valid = 1'b0;
    pre_audio = '0;
    post_audio = '0;
  end

  // delay past the edge so bench control changes have landed
  always @(negedge mclk) begin
    #1;
    sample_valid <= run && gap_q == 4'h0;
    gap_q <= (gap_q == 4'h0) ? period : gap_q - 4'h1;
    for (int c = 0; c < CHANNELS; c++) begin
      w_pre = pick_word(kind_pre);
      w_post = (kind_post == 2'h3) ? w_pre : pick_word(kind_post);
      pre_audio[c*SERIAL_W+:SERIAL_W] <= w_pre;
      post_audio[c*SERIAL_W+:SERIAL_W] <= w_post;
    end
  end
endmodule

// *** verification/drc_checker_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// output timing and bypass checks
// ****************************************
module drc_checker
  import dynamics_pkg::*;
(
  input wire logic                         mclk,
  input wire logic                         reset_n,
  input wire logic                         sample_valid,
  input wire logic [CHANNELS*SERIAL_W-1:0] post_volume_audio,
  input wire logic [CHANNELS*SERIAL_W-1:0] pre_volume_audio,
  input wire logic                         multi_tap_post,
  input wire logic                         single_tap_post,
  input wire logic                         multi_enable,
  input wire logic                         single_enable,
  input wire logic                         six_channel_mode,
  input wire logic [CHANNELS*SERIAL_W-1:0] audio_out,
  input wire logic                         audio_out_valid,
  input wire logic [COEF_W-1:0]            multi_gain,
  input wire logic [COEF_W-1:0]            single_gain
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // audio at the selected tap, per compressor
  logic [CHANNELS*SERIAL_W-1:0] tap_seen;
  logic [SERIAL_W-1:0]          last_seen;
  assign tap_seen  = multi_tap_post ? post_volume_audio : pre_volume_audio;
  assign last_seen = single_tap_post ? post_volume_audio[255:224] : pre_volume_audio[255:224];
  sequence s_take; sample_valid; endsequence
  sequence s_idle; !sample_valid; endsequence
  a_valid_follows: assert property (s_take |=> audio_out_valid)
    else $error("no output valid after sample");
  a_valid_cause: assert property (audio_out_valid |-> $past(sample_valid))
    else $error("output valid without sample");
  a_audio_holds: assert property (s_idle |=> $stable(audio_out))
    else $error("audio changed without sample");
  a_gain_holds: assert property (s_idle |=> $stable(multi_gain) && $stable(single_gain))
    else $error("gain changed without sample");
  a_multi_off: assert property (s_take ##0 !multi_enable |=> multi_gain == UNITY_COEF)
    else $error("disabled multichannel gain not unity");
  a_single_off: assert property (s_take ##0 !single_enable |=> single_gain == UNITY_COEF)
    else $error("disabled single gain not unity");
  a_reset_vals: assert property ($rose(reset_n) |-> !audio_out_valid && audio_out == '0
      && multi_gain == UNITY_COEF && single_gain == UNITY_COEF)
    else $error("outputs not at reset values");
  a_six_bypass: assert property (s_take ##0 six_channel_mode |=>
      audio_out[191:128] == $past(tap_seen[191:128]))
    else $error("six channel mode gained channels five or six");
  a_ch8_unity: assert property (s_take ##0 (!single_enable && single_gain == UNITY_COEF)
      |=> audio_out[255:224] == $past(last_seen))
    else $error("channel eight changed at unity gain");
  a_ch1_unity: assert property (s_take ##0 (!multi_enable && multi_gain == UNITY_COEF)
      |=> audio_out[31:0] == $past(tap_seen[31:0]))
    else $error("channel one changed at unity gain");
endmodule

bind dynamic_range_control drc_checker i_checker (
  .mclk(mclk), .reset_n(reset_n), .sample_valid(sample_valid),
  .post_volume_audio(post_volume_audio), .pre_volume_audio(pre_volume_audio),
  .multi_tap_post(multi_tap_post), .single_tap_post(single_tap_post), .multi_enable(multi_enable),
  .single_enable(single_enable), .six_channel_mode(six_channel_mode), .audio_out(audio_out),
  .audio_out_valid(audio_out_valid), .multi_gain(multi_gain), .single_gain(single_gain)
);

// *** verification/dynamic_range_control_tb_top.sv ***
`timescale 1ns/1ps
module dynamic_range_control_tb_top
  import dynamics_pkg::*;
;
  typedef struct packed {logic [7:0] mask; logic [255:0] audio;} note_type;
  logic                         mclk = 1'b0;
  logic                         reset_n, run, multi_tap_post, single_tap_post;
  logic                         multi_enable, single_enable, six_channel_mode;
  logic                         sample_valid, audio_out_valid, m_prev, s_prev;
  logic [1:0]                   kind_pre, kind_post;
  logic [3:0]                   period;
  logic [CHANNELS*SERIAL_W-1:0] pre_audio, post_audio, audio_out;
  logic [COEF_W-1:0]            input_mix_gain, multi_gain, single_gain, g_multi, g_single;
  curve_type                    curve;
  timing_type                   timing;
  note_type                     notes[$];
  note_type                     nt, nt_out;
  int                           n_mismatch = 0, n_compared = 0, cycles = 0;

  always #5 mclk = ~mclk;

  dynamic_range_control i_dut (.mclk(mclk), .reset_n(reset_n), .sample_valid(sample_valid),
    .pre_volume_audio(pre_audio), .post_volume_audio(post_audio),
    .multi_tap_post(multi_tap_post), .single_tap_post(single_tap_post),
    .multi_enable(multi_enable), .single_enable(single_enable),
    .six_channel_mode(six_channel_mode), .input_mix_gain(input_mix_gain),
    .multi_curve(curve), .single_curve(curve), .multi_timing(timing), .single_timing(timing),
    .audio_out(audio_out), .audio_out_valid(audio_out_valid), .multi_gain(multi_gain),
    .single_gain(single_gain));

  audio_source i_source (.mclk(mclk), .run(run), .period(period), .kind_pre(kind_pre),
    .kind_post(kind_post), .sample_valid(sample_valid), .pre_audio(pre_audio),
    .post_audio(post_audio));

  task check(input logic [255:0] seen, input logic [255:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task samples(input int n);
    repeat (n) begin
      @(posedge mclk);
      while (sample_valid !== 1'b1) @(posedge mclk);
    end
    @(negedge mclk);
  endtask

  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // expectation notes and output monitor
  // ****************************************
  always @(posedge mclk) begin
    if (reset_n !== 1'b1) begin
      notes.delete();
      m_prev = 1'b0;
      s_prev = 1'b0;
    end else if (sample_valid === 1'b1) begin
      nt.mask = {!s_prev, {7{!m_prev}}};
      if (six_channel_mode) nt.mask[5:4] = 2'b11;
      if (pre_audio !== post_audio) nt.mask = 8'h00;
      nt.audio = post_audio;
      notes.push_back(nt);
      m_prev = multi_enable;
      s_prev = single_enable;
    end
  end

  always @(negedge mclk) begin
    if (reset_n === 1'b1 && audio_out_valid === 1'b1) begin
      if (notes.size() == 0) check(256'(audio_out_valid), 256'(1'b0), "extra output");
      else begin
        nt_out = notes.pop_front();
        for (int c = 0; c < CHANNELS; c++) begin
          if (nt_out.mask[c]) begin
            check(256'(audio_out[c*32+:32]), 256'(nt_out.audio[c*32+:32]), "audio");
          end
        end
      end
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("mismatch at %0t: run timed out", $time);
      end_of_test();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    reset_n = 1'b0;
    run = 1'b0;
    period = 4'h3;
    kind_pre = 2'h2;
    kind_post = 2'h3;
    multi_tap_post = 1'b1;
    single_tap_post = 1'b1;
    multi_enable = 1'b0;
    single_enable = 1'b0;
    six_channel_mode = 1'b0;
    input_mix_gain = UNITY_COEF;
    curve = '{48'hFFFFF6000000, 48'hFFFFFA000000, 48'h000001000000, 48'h000004000000,
              28'h0, 28'h0, 28'h0};
    timing = '{28'h0400000, 28'h0400000, 28'h0400000, 28'h0400000,
               28'h0400000, 28'h0400000};
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    check(256'(multi_gain), 256'(UNITY_COEF), "reset gain");
    check(256'(single_gain), 256'(UNITY_COEF), "reset gain");
    $display("test reset done");
    run = 1'b1;
    period = 4'h0;
    samples(20);
    period = 4'h3;
    samples(20);
    check(256'(multi_gain), 256'(UNITY_COEF), "bypass gain");
    $display("test bypass done");
    for (int s = 0; s < 2; s++) begin
      six_channel_mode = s[0];
      kind_pre = 2'h1;
      multi_enable = 1'b1;
      samples(150);
      check(256'($signed(multi_gain) < $signed(UNITY_COEF)), 256'(1'b1), "high cut");
      check(256'(single_gain), 256'(UNITY_COEF), "single idle");
      multi_enable = 1'b0;
      samples(2);
      $display("test compress done");
    end
    six_channel_mode = 1'b0;
    kind_post = 2'h0;
    multi_enable = 1'b1;
    samples(2);
    single_enable = 1'b1;
    samples(150);
    g_multi = multi_gain;
    g_single = single_gain;
    multi_tap_post = 1'b0;
    single_tap_post = 1'b0;
    samples(150);
    check(256'($signed(multi_gain) < $signed(g_multi)), 256'(1'b1), "tap region");
    check(256'($signed(single_gain) < $signed(g_single)), 256'(1'b1), "tap region");
    g_multi = multi_gain;
    multi_tap_post = 1'b1;
    samples(150);
    check(256'($signed(multi_gain) > $signed(g_multi)), 256'(1'b1), "gain release");
    $display("test tap done");
    run = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    check(256'(multi_gain), 256'(UNITY_COEF), "rerun gain");
    $display("test rerun done");
    end_of_test();
  end
endmodule
